//--- tlm_chan.sv
`timescale 1ns/100ps
`include "tlm_defines.svh"
module tlm_chan (
  tlm_chan_if.chan ch
);
  import tlm_pkg::*;
  localparam int SUB = `TLM_PERIOD_CYCLES / `TLM_SUBPULSES;
  // Total on slots split across sub-pulses; remainder goes to early sub-pulses
  logic [4:0] base;
  logic [2:0] rem;
  logic [23:0] on_len;
  always_comb begin
    base = 5'(ch.code / 5'd8);
    rem = ch.code[2:0];
    on_len = 24'(base) * 24'(`TLM_SLOT_CYCLES);
    if (ch.sub_idx < rem) begin
      on_len = on_len + 24'(`TLM_SLOT_CYCLES);
    end
  end
  // Spread pulses: each sub-period opens with its share of on time
  always_comb begin
    if (!ch.run) begin
      ch.on = 1'b0;
    end else if (ch.code == `TLM_CODE_ALWAYS_ON) begin
      ch.on = 1'b1;
    end else begin
      ch.on = (ch.sub_cnt < on_len) && (ch.sub_cnt < 24'(SUB));
    end
  end
endmodule : tlm_chan

//--- tlm_chan_if.sv
`timescale 1ns/100ps
interface tlm_chan_if;
  import tlm_pkg::*;
  logic run;
  logic [2:0] sub_idx;
  logic [23:0] sub_cnt;
  tlm_code_t code;
  logic on;
  modport ctl (output run, output sub_idx, output sub_cnt, output code, input on);
  modport chan (input run, input sub_idx, input sub_cnt, input code, output on);
endinterface : tlm_chan_if

//--- tlm_defines.svh
`ifndef TLM_DEFINES_SVH
`define TLM_DEFINES_SVH
// Register byte addresses on the internal register port
`define TLM_RED_CTRL_ADDR 8'h54
`define TLM_GREEN_CTRL_ADDR 8'h55
`define TLM_BLUE_CTRL_ADDR 8'h56
`define TLM_CTRL_RESET 8'h00
// Field positions
`define TLM_ENABLE_BIT 7
`define TLM_PHASE_BIT 6
`define TLM_SPARE_BIT 5
`define TLM_LEVEL_MSB 7
`define TLM_LEVEL_LSB 5
`define TLM_CODE_MSB 4
`define TLM_CODE_LSB 0
`define TLM_CODE_ALWAYS_ON 5'h1f
// Timing, figures in their own units
`define TLM_CLK_MHZ 200
`define TLM_PERIOD_HZ 160
`define TLM_PHASE_US 200
// One slot is 1/5.4 ms = 1000/5.4 us; slot cycles = 200e6 / 5400
`define TLM_SLOT_CYCLES ((`TLM_CLK_MHZ * 1000000) / 5400)
`define TLM_PERIOD_CYCLES ((`TLM_CLK_MHZ * 1000000) / `TLM_PERIOD_HZ)
`define TLM_PHASE_CYCLES (`TLM_PHASE_US * `TLM_CLK_MHZ)
// Sub-pulses per modulation period
`define TLM_SUBPULSES 8
`endif

//--- tlm_led_model.sv
`timescale 1ns/100ps
// Three LEDs; dark whenever the sink current code is zero
module tlm_led_model (
  input wire logic clk_i,
  input wire logic clr_i,
  input wire logic [2:0] sink_i,
  input wire logic [2:0] level_i,
  output logic [15:0] lit_o [3],
  output logic [15:0] both_o [2]
);
  // Cycles with two sinks on together: red-green, red-blue
  always_ff @(posedge clk_i) begin
    both_o[0] <= clr_i ? 16'h0000 : both_o[0] + 16'(sink_i[0] && sink_i[1]);
    both_o[1] <= clr_i ? 16'h0000 : both_o[1] + 16'(sink_i[0] && sink_i[2]);
  end
  // Lit cycles per colour, red at index 0
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 3; i++) begin
      lit_o[i] <= clr_i ? 16'h0000 : lit_o[i] + 16'(sink_i[i] && level_i != 3'h0);
    end
  end
endmodule : tlm_led_model

//--- tlm_pkg.sv
package tlm_pkg;
  typedef logic [2:0] tlm_level_t;
  typedef logic [4:0] tlm_code_t;
  typedef logic [7:0] tlm_byte_t;
  // Modulator sequencing, Gray coded along idle -> run
  typedef enum logic [1:0] {
    TLM_IDLE = 2'b00,
    TLM_LOAD = 2'b01,
    TLM_RUN = 2'b11
  } tlm_state_t;
endpackage : tlm_pkg

//--- tlm_top.sv
`timescale 1ns/100ps
`include "tlm_defines.svh"
// What this block does
// - Enable bit gates all three sinks
// - Shared 3-bit sink level drives every pin
// - Sink level codes map to 0..27.3 mA
// - No flashing, runs continuously when enabled
// - Each colour has own 5-bit intensity
// - Spread pulses repeating at 160 Hz
// - One colour delayed by 200 us
// - Phase 0: green offset, red/blue aligned
// - Phase 1: blue offset, red/green aligned
// - On time equals code over 5.4 ms
// - Code 31 holds sink fully on
module tlm_top #(
  parameter int PERIOD_CYCLES = `TLM_PERIOD_CYCLES,
  parameter int PHASE_CYCLES = `TLM_PHASE_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire tlm_pkg::tlm_byte_t reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic red_sink_pin_o,
  output logic green_sink_pin_o,
  output logic blue_sink_pin_o,
  output logic [2:0] tricolor_b_sink_level_o
);
  import tlm_pkg::*;
  localparam int SUB = PERIOD_CYCLES / `TLM_SUBPULSES;

  tlm_byte_t red_ctrl_reg;
  tlm_byte_t green_ctrl_reg;
  tlm_byte_t blue_ctrl_reg;
  tlm_state_t state_reg;
  logic [23:0] main_cnt_reg;
  logic [23:0] off_cnt_reg;
  tlm_code_t red_code_reg, green_code_reg, blue_code_reg;
  tlm_level_t level_reg;
  logic phase_reg;
  logic boundary;
  // Next values of the registered outputs
  logic red_sink_next;
  logic green_sink_next;
  logic blue_sink_next;
  tlm_level_t level_next;

  // Red control: every bit is a live setting
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      red_ctrl_reg <= `TLM_CTRL_RESET;
    end else if (reg_wr_i && (reg_addr_i == `TLM_RED_CTRL_ADDR)) begin
      red_ctrl_reg <= reg_wdata_i;
    end
  end

  // Green control: spare bit held low so it reads back zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      green_ctrl_reg <= `TLM_CTRL_RESET;
    end else if (reg_wr_i && (reg_addr_i == `TLM_GREEN_CTRL_ADDR)) begin
      green_ctrl_reg <= reg_wdata_i & 8'hdf;
    end
  end

  // Blue control: only the intensity field exists
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      blue_ctrl_reg <= `TLM_CTRL_RESET;
    end else if (reg_wr_i && (reg_addr_i == `TLM_BLUE_CTRL_ADDR)) begin
      blue_ctrl_reg <= reg_wdata_i & 8'h1f;
    end
  end

  // Read port; unmapped addresses read zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `TLM_RED_CTRL_ADDR: reg_rdata_o <= red_ctrl_reg;
        `TLM_GREEN_CTRL_ADDR: reg_rdata_o <= green_ctrl_reg;
        `TLM_BLUE_CTRL_ADDR: reg_rdata_o <= blue_ctrl_reg;
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // Enable drops at once; start waits one load cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= TLM_IDLE;
    end else if (!green_ctrl_reg[`TLM_ENABLE_BIT]) begin
      state_reg <= TLM_IDLE;
    end else begin
      unique case (state_reg)
        TLM_IDLE: state_reg <= TLM_LOAD;
        TLM_LOAD: state_reg <= TLM_RUN;
        TLM_RUN: state_reg <= TLM_RUN;
        default: state_reg <= TLM_IDLE;
      endcase
    end
  end

  // Load cycle primes the shadows before the first period starts
  assign boundary = (state_reg == TLM_LOAD) || (main_cnt_reg == 24'(PERIOD_CYCLES - 1));

  // Period counter, free-running while enabled
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      main_cnt_reg <= 24'h000000;
    end else if (state_reg != TLM_RUN || boundary) begin
      main_cnt_reg <= 24'h000000;
    end else begin
      main_cnt_reg <= main_cnt_reg + 24'h000001;
    end
  end

  // Offset count trails the main count by the phase delay;
  // primed while idle so the delay already holds in the first period
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      off_cnt_reg <= 24'h000000;
    end else if (state_reg != TLM_RUN) begin
      off_cnt_reg <= 24'(PERIOD_CYCLES - PHASE_CYCLES);
    end else if (off_cnt_reg == 24'(PERIOD_CYCLES - 1)) begin
      off_cnt_reg <= 24'h000000;
    end else begin
      off_cnt_reg <= off_cnt_reg + 24'h000001;
    end
  end

  // Code shadows; only swapped at period edges to avoid runt pulses
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      red_code_reg <= 5'h00;
      green_code_reg <= 5'h00;
      blue_code_reg <= 5'h00;
    end else if (boundary) begin
      red_code_reg <= red_ctrl_reg[`TLM_CODE_MSB:`TLM_CODE_LSB];
      green_code_reg <= green_ctrl_reg[`TLM_CODE_MSB:`TLM_CODE_LSB];
      blue_code_reg <= blue_ctrl_reg[`TLM_CODE_MSB:`TLM_CODE_LSB];
    end
  end

  // Level shadow; a mid-period change would step the sink current
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_reg <= 3'h0;
    end else if (boundary) begin
      level_reg <= red_ctrl_reg[`TLM_LEVEL_MSB:`TLM_LEVEL_LSB];
    end
  end

  // Phase shadow; swapping counters mid-period could split a pulse
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_reg <= 1'b0;
    end else if (boundary) begin
      phase_reg <= green_ctrl_reg[`TLM_PHASE_BIT];
    end
  end

  // Channel timing: aligned or offset counter per phase choice
  tlm_chan_if r_if ();
  tlm_chan_if g_if ();
  tlm_chan_if b_if ();
  logic run;
  logic [23:0] g_cnt, b_cnt;
  assign run = (state_reg == TLM_RUN);
  assign g_cnt = phase_reg ? main_cnt_reg : off_cnt_reg;
  assign b_cnt = phase_reg ? off_cnt_reg : main_cnt_reg;

  // Red always runs on the main count
  assign r_if.run = run;
  assign r_if.code = red_code_reg;
  assign r_if.sub_idx = 3'(main_cnt_reg / 24'(SUB));
  assign r_if.sub_cnt = 24'(main_cnt_reg % 24'(SUB));

  // Green takes the delayed count while phase is 0
  assign g_if.run = run;
  assign g_if.code = green_code_reg;
  assign g_if.sub_idx = 3'(g_cnt / 24'(SUB));
  assign g_if.sub_cnt = 24'(g_cnt % 24'(SUB));

  // Blue takes the delayed count while phase is 1
  assign b_if.run = run;
  assign b_if.code = blue_code_reg;
  assign b_if.sub_idx = 3'(b_cnt / 24'(SUB));
  assign b_if.sub_cnt = 24'(b_cnt % 24'(SUB));

  tlm_chan u_red (.ch(r_if));
  tlm_chan u_green (.ch(g_if));
  tlm_chan u_blue (.ch(b_if));

  // Next pin values; leaving run forces every sink off
  assign red_sink_next = run & r_if.on;
  assign green_sink_next = run & g_if.on;
  assign blue_sink_next = run & b_if.on;
  assign level_next = run ? level_reg : 3'h0;

  // Registered pin drives, so the pads never see decode glitches
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      red_sink_pin_o <= 1'b0;
      green_sink_pin_o <= 1'b0;
      blue_sink_pin_o <= 1'b0;
    end else begin
      red_sink_pin_o <= red_sink_next;
      green_sink_pin_o <= green_sink_next;
      blue_sink_pin_o <= blue_sink_next;
    end
  end

  // Level code reads zero while disabled
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tricolor_b_sink_level_o <= 3'h0;
    end else begin
      tricolor_b_sink_level_o <= level_next;
    end
  end
endmodule : tlm_top

//--- tlm_top_assertions.sv
`timescale 1ns/100ps
`include "tlm_defines.svh"
// Port-only watcher; a register shadow stands in for the hidden fields
module tlm_top_assertions #(
  parameter int PERIOD_CYCLES = `TLM_PERIOD_CYCLES,
  parameter int PHASE_CYCLES = `TLM_PHASE_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire tlm_pkg::tlm_byte_t reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic red_sink_pin_o,
  input wire logic green_sink_pin_o,
  input wire logic blue_sink_pin_o,
  input wire logic [2:0] tricolor_b_sink_level_o
);
  import tlm_pkg::*;
  logic [7:0] rs, gs, bs;
  int q;
  logic st;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Shadow copy, forced-zero bits masked
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rs <= 8'h00;
      gs <= 8'h00;
      bs <= 8'h00;
    end else if (reg_wr_i) begin
      if (reg_addr_i == 8'h54) rs <= reg_wdata_i;
      if (reg_addr_i == 8'h55) gs <= reg_wdata_i & 8'hdf;
      if (reg_addr_i == 8'h56) bs <= reg_wdata_i & 8'h1f;
    end
  end
  // Settings only land at a period boundary, so wait a full period
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) q <= 0;
    else if (reg_wr_i) q <= 0;
    else if (q <= PERIOD_CYCLES + 8) q <= q + 1;
  end
  assign st = q > PERIOD_CYCLES + 8;
  sequence s_off; (!gs[7]) [*3]; endsequence
  sequence s_rd(logic [7:0] a); reg_rd_i && reg_addr_i == a ##1 !reg_rd_i; endsequence
  property p_off; s_off |-> !(red_sink_pin_o | green_sink_pin_o | blue_sink_pin_o); endproperty
  a_off: assert property (p_off) else $error("sink on while disabled");
  property p_lvl; st && gs[7] |-> tricolor_b_sink_level_o == rs[7:5]; endproperty
  a_lvl: assert property (p_lvl) else $error("sink level differs");
  property p_red; s_rd(8'h54) |=> reg_rdata_o == $past(rs, 2); endproperty
  a_red: assert property (p_red) else $error("red readback wrong");
  property p_grn; s_rd(8'h55) |=> reg_rdata_o == $past(gs, 2); endproperty
  a_grn: assert property (p_grn) else $error("green readback wrong");
  property p_blu; s_rd(8'h56) |=> reg_rdata_o == $past(bs, 2); endproperty
  a_blu: assert property (p_blu) else $error("blue readback wrong");
  property p_full; st && gs[7] && rs[4:0] == 5'h1f |-> red_sink_pin_o; endproperty
  a_full: assert property (p_full) else $error("red not held on");
  property p_zero; st && gs[4:0] == 5'h00 |-> !green_sink_pin_o; endproperty
  a_zero: assert property (p_zero) else $error("green lit at code 0");
  property p_run; st && gs[7] && bs[4:0] == 5'h1f |-> blue_sink_pin_o; endproperty
  a_run: assert property (p_run) else $error("blue stopped");
endmodule : tlm_top_assertions
bind tlm_top tlm_top_assertions #(.PERIOD_CYCLES(PERIOD_CYCLES), .PHASE_CYCLES(PHASE_CYCLES))
  tlm_top_assertions_inst (.*);

//--- tlm_top_tb.sv
`timescale 1ns/100ps
module tlm_top_tb;
  import tlm_pkg::*;
  // Scaled period; the phase delay equals one sub-period so two
  // one-slot pulses abut but never overlap; full-size timing leaves a gap
  localparam int P = 4000;
  localparam int SUB = P / 8;
  localparam logic [15:0] FULL = 16'(P);
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  tlm_byte_t reg_wdata_i = 8'h00;
  logic [7:0] reg_rdata_o;
  logic red_sink_pin_o, green_sink_pin_o, blue_sink_pin_o;
  logic [2:0] tricolor_b_sink_level_o;
  logic clr = 1'b1;
  logic [15:0] lit [3];
  logic [15:0] both [2];
  int n_mismatch = 0;
  int cmp_count = 0;
  always #2.5 clk_i = ~clk_i;
  tlm_top #(.PERIOD_CYCLES(P), .PHASE_CYCLES(SUB)) tlm_top_inst (.*);
  tlm_led_model tlm_led_model_inst (.clk_i(clk_i), .clr_i(clr), .lit_o(lit), .both_o(both),
    .sink_i({blue_sink_pin_o, green_sink_pin_o, red_sink_pin_o}), .level_i(tricolor_b_sink_level_o));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) $display("ERROR %s expected %0h seen %0h", n, e, g);
    if (g !== e) n_mismatch++;
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    @(negedge clk_i);
    chk("rdata", 16'(e), 16'(reg_rdata_o));
  endtask : rd
  // Lets new settings land, then counts lit cycles over one period
  task automatic lit3(input logic [15:0] r, input logic [15:0] g, input logic [15:0] b);
    repeat (P + 4) @(negedge clk_i);
    clr = 1'b1;
    @(negedge clk_i);
    clr = 1'b0;
    repeat (P) @(negedge clk_i);
    chk("red lit", r, lit[0]);
    chk("green lit", g, lit[1]);
    chk("blue lit", b, lit[2]);
  endtask : lit3
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  // Main sequence
  initial begin
    repeat (4) @(negedge clk_i);
    rst_n_i = 1'b1;
    rd(8'h54, 8'h00);
    rd(8'h55, 8'h00);
    rd(8'h56, 8'h00);
    $display("reset values done");
    wr(8'h54, 8'hff);
    wr(8'h55, 8'hff);
    wr(8'h56, 8'hff);
    rd(8'h54, 8'hff);
    rd(8'h55, 8'hdf);
    rd(8'h56, 8'h1f);
    rd(8'h57, 8'h00);
    lit3(FULL, FULL, FULL);
    chk("level", 16'h0007, 16'(tricolor_b_sink_level_o));
    $display("full on done");
    wr(8'h54, 8'h80);
    wr(8'h55, 8'h80);
    lit3(16'h0000, 16'h0000, FULL);
    chk("level", 16'h0004, 16'(tricolor_b_sink_level_o));
    $display("dark codes done");
    wr(8'h54, 8'h81);
    wr(8'h55, 8'h81);
    wr(8'h56, 8'h01);
    lit3(16'(SUB), 16'(SUB), 16'(SUB));
    chk("red green overlap", 16'h0000, both[0]);
    chk("red blue overlap", 16'(SUB), both[1]);
    $display("phase 0 done");
    wr(8'h55, 8'hc1);
    lit3(16'(SUB), 16'(SUB), 16'(SUB));
    chk("red green overlap", 16'(SUB), both[0]);
    chk("red blue overlap", 16'h0000, both[1]);
    $display("phase 1 done");
    // One slot outlasts a scaled sub-period, so code k below 8 fills k of them
    wr(8'h54, 8'h83);
    wr(8'h55, 8'hc5);
    wr(8'h56, 8'h1e);
    lit3(16'(3 * SUB), 16'(5 * SUB), FULL);
    $display("short codes done");
    wr(8'h55, 8'h1f);
    repeat (3) @(negedge clk_i);
    chk("sinks", 16'h0000, 16'({red_sink_pin_o, green_sink_pin_o, blue_sink_pin_o}));
    chk("level", 16'h0000, 16'(tricolor_b_sink_level_o));
    $display("disable done");
    print_verdict();
  end
  // Watchdog, about half again the expected run
  initial begin
    #(P * 5 * 15);
    n_mismatch++;
    print_verdict();
  end
endmodule : tlm_top_tb
